// File: verilog/emul_trig_seq.sv
`default_nettype none
//Contract
//- Configured and controlled only through serial port
//- Up to eight memory bus comparator triggers
//- Up to two register write triggers
//- Each memory trigger picks address or data
//- Compare equal, unequal, greater-equal, less-equal
//- Memory compare mask, per bit or byte
//- Qualify by read, write, DMA, fetch
//- Register write value compared with reference
//- Watched register chosen per trigger
//- Register compare restricted by bit mask
//- Triggers combine into eight complex triggers
//- Triggers feed stop, storage and sequencer
//- Sequencer has exactly four states
//- Two transitions per state, any target
//- Reset trigger forces state zero
//- Start at zero, act at three
//- Enabled sequencer gates break and storage
//- Trace records address, data, access kind
//- Trace buffer holds eight entries
//- Peripheral clocks held globally or per module
//- Halt keeps selected clocks running, stops others
module emul_trig_seq
   import emul_trig_pkg::*;
(
   input  wire logic             CLOCK,
   input  wire logic             NRST,
   input  wire mem_cycle_s       MEM_CYCLE,
   input  wire reg_write_s       REG_WRITE,
   input  wire logic             JTAG_TCK,
   input  wire logic             JTAG_SEL,
   input  wire logic             JTAG_TDI,
   output logic                  JTAG_TDO,
   output logic                  CPU_STOP,
   output logic [TRIGS-1:0]      TRIG_HIT,
   output logic [1:0]            SEQ_STATE,
   output logic [PERIPHS-1:0]    PERIPH_CLK_RUN
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [FRAME_BITS-1:0] shift_in;
   logic [WORD_BITS-1:0]  shift_out;
   logic                  sel_q;
   logic [WORD_BITS-1:0]  readback;
   logic                  sel_m;
   logic                  sel_s;
   logic                  sel_d;
   logic                  frame_done;
   logic [3:0]            cmd_grp;
   logic [3:0]            cmd_idx;
   logic [WORD_BITS-1:0]  cmd_data;
   logic [31:0]           mem_ref  [MEM_TRIGS];
   logic [31:0]           mem_ctl  [MEM_TRIGS];
   logic [31:0]           reg_ref  [REG_TRIGS];
   logic [31:0]           reg_ctl  [REG_TRIGS];
   logic [31:0]           comb_cfg [COMBOS];
   logic [31:0]           seq_cfg  [4];
   logic [31:0]           seq_rst;
   logic [31:0]           react;
   logic [31:0]           clk_cfg;
   logic                  rearm;
   logic                  release_cmd;
   logic [TRIGS-1:0]      next_trig;
   logic [TRIGS-1:0]      trig;
   logic [COMBOS-1:0]     comb;
   mem_cycle_s            bus_q;
   seq_state_e            seq_state;
   seq_state_e            next_seq;
   logic                  seq_en;
   logic                  seq_reset_hit;
   logic                  gate;
   logic                  brk_acc;
   logic                  sto_acc;
   logic                  halted;
   trace_entry_s          trace_mem [TRACE_DEPTH];
   trace_entry_s          entry;
   logic [3:0]            trace_cnt;
   logic [3:0]            trace_base;
   logic [WORD_BITS-1:0]  rd_word;

   // ----------------------------------------------------------------
   // Link side: serial shift on the debugger clock
   // ----------------------------------------------------------------
   always_ff @(posedge JTAG_TCK or negedge NRST) begin
      if (!NRST) begin
         shift_in <= '0;
      end else if (JTAG_SEL) begin
         shift_in <= {shift_in[FRAME_BITS-2:0], JTAG_TDI};
      end
   end

   always_ff @(posedge JTAG_TCK or negedge NRST) begin
      if (!NRST) begin
         sel_q     <= 1'b0;
         shift_out <= '0;
         JTAG_TDO  <= 1'b0;
      end else begin
         sel_q <= JTAG_SEL;
         if (JTAG_SEL && !sel_q) begin
            shift_out <= readback;
            JTAG_TDO  <= readback[WORD_BITS-1];
         end else if (JTAG_SEL) begin
            shift_out <= {shift_out[WORD_BITS-2:0], 1'b0};
            JTAG_TDO  <= shift_out[WORD_BITS-2];
         end
      end
   end

   // ----------------------------------------------------------------
   // Frame end crossing into the core clock
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         sel_m <= 1'b0;
         sel_s <= 1'b0;
         sel_d <= 1'b0;
      end else begin
         sel_m <= JTAG_SEL;
         sel_s <= sel_m;
         sel_d <= sel_s;
      end
   end

   assign frame_done = sel_d && !sel_s;
   assign cmd_grp    = shift_in[FRAME_BITS-1 -: 4];
   assign cmd_idx    = shift_in[FRAME_BITS-5 -: 4];
   assign cmd_data   = shift_in[WORD_BITS-1:0];

   // ----------------------------------------------------------------
   // Configuration writes
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         for (int i = 0; i < MEM_TRIGS; i++) begin
            mem_ref[i] <= CFG_RESET;
            mem_ctl[i] <= CFG_RESET;
         end
         for (int i = 0; i < REG_TRIGS; i++) begin
            reg_ref[i] <= CFG_RESET;
            reg_ctl[i] <= CFG_RESET;
         end
         for (int i = 0; i < COMBOS; i++) begin
            comb_cfg[i] <= CFG_RESET;
         end
         for (int i = 0; i < 4; i++) begin
            seq_cfg[i] <= CFG_RESET;
         end
         seq_rst <= CFG_RESET;
         react   <= CFG_RESET;
         clk_cfg <= CFG_RESET;
      end else if (frame_done) begin
         if (cmd_grp == GRP_MEM_REF && cmd_idx < 4'(MEM_TRIGS)) begin
            mem_ref[cmd_idx[2:0]] <= cmd_data;
         end else if (cmd_grp == GRP_MEM_CTL && cmd_idx < 4'(MEM_TRIGS)) begin
            mem_ctl[cmd_idx[2:0]] <= cmd_data;
         end else if (cmd_grp == GRP_REG_REF && cmd_idx < 4'(REG_TRIGS)) begin
            reg_ref[cmd_idx[0]] <= cmd_data;
         end else if (cmd_grp == GRP_REG_CTL && cmd_idx < 4'(REG_TRIGS)) begin
            reg_ctl[cmd_idx[0]] <= cmd_data;
         end else if (cmd_grp == GRP_COMB && cmd_idx < 4'(COMBOS)) begin
            comb_cfg[cmd_idx[2:0]] <= cmd_data;
         end else if (cmd_grp == GRP_REACT) begin
            react <= cmd_data;
         end else if (cmd_grp == GRP_SEQ && cmd_idx < SEQ_RST_IDX) begin
            seq_cfg[cmd_idx[1:0]] <= cmd_data;
         end else if (cmd_grp == GRP_SEQ && cmd_idx == SEQ_RST_IDX) begin
            seq_rst <= cmd_data;
         end else if (cmd_grp == GRP_CLK) begin
            clk_cfg <= cmd_data;
         end
      end
   end

   // One-cycle command pulses
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         rearm       <= 1'b0;
         release_cmd <= 1'b0;
      end else begin
         rearm       <= frame_done && cmd_grp == GRP_CMD && cmd_data[CMD_REARM];
         release_cmd <= frame_done && cmd_grp == GRP_CMD && cmd_data[CMD_RELS];
      end
   end

   // ----------------------------------------------------------------
   // Trigger comparators
   // ----------------------------------------------------------------
   for (genvar g = 0; g < MEM_TRIGS; g++) begin : g_mem
      logic [BUS_W-1:0] val;
      logic [BUS_W-1:0] mask;
      logic [3:0]       acc;
      logic [3:0]       kind;
      assign val  = mem_ctl[g][MCTL_BUS] ? MEM_CYCLE.data : MEM_CYCLE.addr;
      assign mask = mem_ctl[g][MCTL_BYTE] ?
                    {{8{mem_ref[g][REF_MASK+1]}}, {8{mem_ref[g][REF_MASK]}}} :
                    mem_ref[g][REF_MASK +: BUS_W];
      assign acc  = mem_ctl[g][MCTL_ACC +: 4];
      assign kind = {MEM_CYCLE.fetch, MEM_CYCLE.dma, MEM_CYCLE.write, MEM_CYCLE.read};
      assign next_trig[g] = MEM_CYCLE.valid && mem_ctl[g][MCTL_EN]
                            && (acc == 4'h0 || (acc & kind) != 4'h0)
                            && cmp_hit(cmp_op_e'(mem_ctl[g][MCTL_OP +: 2]), val,
                                       mem_ref[g][REF_VAL +: BUS_W], mask);
   end

   for (genvar g = 0; g < REG_TRIGS; g++) begin : g_reg
      assign next_trig[MEM_TRIGS+g] = REG_WRITE.valid && reg_ctl[g][RCTL_EN]
                  && REG_WRITE.num == reg_ctl[g][RCTL_NUM +: 4]
                  && cmp_hit(cmp_op_e'(reg_ctl[g][RCTL_OP +: 2]), REG_WRITE.data,
                             reg_ref[g][REF_VAL +: BUS_W],
                             reg_ref[g][REF_MASK +: BUS_W]);
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         trig  <= '0;
         bus_q <= '0;
      end else begin
         trig  <= next_trig;
         bus_q <= MEM_CYCLE;
      end
   end

   assign TRIG_HIT = trig;

   // ----------------------------------------------------------------
   // Complex triggers and reactions
   // ----------------------------------------------------------------
   for (genvar c = 0; c < COMBOS; c++) begin : g_comb
      assign comb[c] = comb_cfg[c][TRIGS-1:0] != '0
                       && (trig & comb_cfg[c][TRIGS-1:0]) == comb_cfg[c][TRIGS-1:0];
   end

   assign seq_en  = react[REACT_SEQ];
   assign gate    = !seq_en || seq_state == SEQ_S3;
   assign brk_acc = gate && (comb & react[REACT_BRK +: COMBOS]) != '0;
   assign sto_acc = gate && (comb & react[REACT_STO +: COMBOS]) != '0;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   assign seq_reset_hit = seq_rst[SEQ_RSTEN] && comb[seq_rst[2:0]];

   always_comb begin
      next_seq = seq_state;
      if (seq_reset_hit) begin
         next_seq = SEQ_S0;
      end else if (comb[seq_cfg[seq_state][SEQ_TRA +: 3]]) begin
         next_seq = seq_state_e'(seq_cfg[seq_state][SEQ_TGA +: 2]);
      end else if (comb[seq_cfg[seq_state][SEQ_TRB +: 3]]) begin
         next_seq = seq_state_e'(seq_cfg[seq_state][SEQ_TGB +: 2]);
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         seq_state <= SEQ_S0;
      end else begin
         seq_state <= next_seq;
      end
   end

   assign SEQ_STATE = seq_state;

   // ----------------------------------------------------------------
   // Break and clock control
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         halted <= 1'b0;
      end else if (brk_acc) begin
         halted <= 1'b1;
      end else if (release_cmd) begin
         halted <= 1'b0;
      end
   end

   assign CPU_STOP = halted;

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         PERIPH_CLK_RUN <= CLK_ALL_RUN;
      end else if (halted && clk_cfg[CLK_GLOB]) begin
         PERIPH_CLK_RUN <= {PERIPHS{clk_cfg[CLK_GRUN]}};
      end else if (halted) begin
         PERIPH_CLK_RUN <= clk_cfg[CLK_MASK +: PERIPHS];
      end else begin
         PERIPH_CLK_RUN <= CLK_ALL_RUN;
      end
   end

   // ----------------------------------------------------------------
   // Trace storage
   // ----------------------------------------------------------------
   assign entry.kind = bus_q.fetch ? KIND_FETCH : (bus_q.write ? KIND_WRITE : KIND_READ);
   assign entry.addr = bus_q.addr;
   assign entry.data = bus_q.data;
   assign trace_base = rearm ? 4'h0 : trace_cnt;

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         trace_cnt <= 4'h0;
         for (int i = 0; i < TRACE_DEPTH; i++) begin
            trace_mem[i] <= '0;
         end
      end else if (sto_acc && trace_base < TRACE_FULL_CNT) begin
         trace_mem[trace_base[2:0]] <= entry;
         trace_cnt <= trace_base + 4'h1;
      end else if (rearm) begin
         trace_cnt <= 4'h0;
      end
   end

   // ----------------------------------------------------------------
   // Readback word, stable between frames
   // ----------------------------------------------------------------
   always_comb begin
      rd_word = '0;
      if (cmd_grp == GRP_TRACE && cmd_idx < 4'(TRACE_DEPTH)) begin
         rd_word = {trace_mem[cmd_idx[2:0]].addr, trace_mem[cmd_idx[2:0]].data};
      end else if (cmd_grp == GRP_KIND && cmd_idx < 4'(TRACE_DEPTH)) begin
         rd_word = {30'h0, trace_mem[cmd_idx[2:0]].kind};
      end else if (cmd_grp == GRP_STATUS) begin
         rd_word = {25'h0, halted, seq_state, trace_cnt};
      end else if (cmd_grp == GRP_MEM_CTL && cmd_idx < 4'(MEM_TRIGS)) begin
         rd_word = mem_ctl[cmd_idx[2:0]];
      end else if (cmd_grp == GRP_CLK) begin
         rd_word = clk_cfg;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         readback <= '0;
      end else if (frame_done) begin
         readback <= rd_word;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_mem_trig_cause: assert property (
      @(posedge CLOCK) disable iff (!NRST)
      (trig[MEM_TRIGS-1:0] != '0) |-> $past(MEM_CYCLE.valid))
      else $error("memory trigger without bus cycle");

   chk_reg_trig_cause: assert property (
      @(posedge CLOCK) disable iff (!NRST)
      (trig[TRIGS-1:MEM_TRIGS] != '0) |-> $past(REG_WRITE.valid))
      else $error("register trigger without register write");

   chk_trig_pulse_len: assert property (
      @(posedge CLOCK) disable iff (!NRST)
      (!MEM_CYCLE.valid && !REG_WRITE.valid) |=> (trig == '0))
      else $error("trigger held without a cycle");

   chk_seq_reset_zero: assert property (
      @(posedge CLOCK) disable iff (!NRST)
      seq_reset_hit |=> (seq_state == SEQ_S0))
      else $error("sequencer reset not taken");

   chk_seq_gate_state: assert property (
      @(posedge CLOCK) disable iff (!NRST)
      (seq_en && seq_state != SEQ_S3 && !rearm) |=> (!$rose(CPU_STOP) && $stable(trace_cnt)))
      else $error("event accepted before sequence end");

   chk_break_halts_cpu: assert property (
      @(posedge CLOCK) disable iff (!NRST)
      brk_acc |=> CPU_STOP ##1 (CPU_STOP || $past(release_cmd)))
      else $error("break did not stop cpu");

   chk_trace_full_hold: assert property (
      @(posedge CLOCK) disable iff (!NRST)
      (trace_cnt == TRACE_FULL_CNT && !rearm) |=> (trace_cnt == TRACE_FULL_CNT))
      else $error("full trace changed without re-arm");

   chk_trace_capture: assert property (
      @(posedge CLOCK) disable iff (!NRST)
      (sto_acc && !rearm && trace_cnt < TRACE_FULL_CNT)
      |=> (trace_cnt == $past(trace_cnt) + 4'h1))
      else $error("trace entry not counted");

   chk_clk_global_stop: assert property (
      @(posedge CLOCK) disable iff (!NRST)
      (halted && clk_cfg[CLK_GLOB] && !clk_cfg[CLK_GRUN]) |=> (PERIPH_CLK_RUN == '0))
      else $error("global stop left a clock running");

   chk_frame_load_tdo: assert property (
      @(posedge JTAG_TCK) disable iff (!NRST)
      (JTAG_SEL && !sel_q) |=> (JTAG_TDO == $past(readback[WORD_BITS-1])))
      else $error("readback not loaded at frame start");

endmodule : emul_trig_seq
`default_nettype wire

// File: verilog/emul_trig_pkg.sv
`default_nettype none
package emul_trig_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int MEM_TRIGS   = 8;
   localparam int REG_TRIGS   = 2;
   localparam int TRIGS       = MEM_TRIGS + REG_TRIGS;
   localparam int COMBOS      = 8;
   localparam int TRACE_DEPTH = 8;
   localparam int PERIPHS     = 8;
   localparam int BUS_W       = 16;
   localparam int WORD_BITS   = 32;
   localparam int ADDR_BITS   = 8;
   localparam int FRAME_BITS  = ADDR_BITS + WORD_BITS;
   localparam logic [3:0] TRACE_FULL_CNT = 4'h8;

   // ----------------------------------------------------------------
   // Command address groups (upper nibble), index in lower nibble
   // ----------------------------------------------------------------
   localparam logic [3:0] GRP_MEM_REF  = 4'h0;
   localparam logic [3:0] GRP_MEM_CTL  = 4'h1;
   localparam logic [3:0] GRP_REG_REF  = 4'h2;
   localparam logic [3:0] GRP_REG_CTL  = 4'h3;
   localparam logic [3:0] GRP_COMB     = 4'h4;
   localparam logic [3:0] GRP_REACT    = 4'h5;
   localparam logic [3:0] GRP_CMD      = 4'h6;
   localparam logic [3:0] GRP_SEQ      = 4'h7;
   localparam logic [3:0] GRP_CLK      = 4'h8;
   localparam logic [3:0] GRP_TRACE    = 4'h9;
   localparam logic [3:0] GRP_KIND     = 4'ha;
   localparam logic [3:0] GRP_STATUS   = 4'hb;
   localparam logic [3:0] SEQ_RST_IDX  = 4'h4;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int REF_VAL   = 0;
   localparam int REF_MASK  = 16;
   localparam int MCTL_BUS  = 0;
   localparam int MCTL_OP   = 1;
   localparam int MCTL_ACC  = 3;
   localparam int MCTL_EN   = 7;
   localparam int MCTL_BYTE = 8;
   localparam int RCTL_NUM  = 0;
   localparam int RCTL_OP   = 4;
   localparam int RCTL_EN   = 6;
   localparam int REACT_BRK = 0;
   localparam int REACT_STO = 8;
   localparam int REACT_SEQ = 16;
   localparam int CMD_REARM = 0;
   localparam int CMD_RELS  = 1;
   localparam int SEQ_TRA   = 0;
   localparam int SEQ_TGA   = 3;
   localparam int SEQ_TRB   = 5;
   localparam int SEQ_TGB   = 8;
   localparam int SEQ_RSTEN = 3;
   localparam int CLK_MASK  = 0;
   localparam int CLK_GLOB  = 8;
   localparam int CLK_GRUN  = 9;
   localparam int ACC_READ  = 0;
   localparam int ACC_WRITE = 1;
   localparam int ACC_DMA   = 2;
   localparam int ACC_FETCH = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] CFG_RESET = 32'h0;
   localparam logic [7:0]  CLK_ALL_RUN = 8'hff;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {CMP_EQ, CMP_NE, CMP_GE, CMP_LE} cmp_op_e;
   typedef enum logic [1:0] {SEQ_S0, SEQ_S1, SEQ_S2, SEQ_S3} seq_state_e;
   typedef enum logic [1:0] {KIND_READ, KIND_WRITE, KIND_FETCH} trace_kind_e;

   typedef struct packed {
      logic [BUS_W-1:0] addr;
      logic [BUS_W-1:0] data;
      logic             valid;
      logic             read;
      logic             write;
      logic             dma;
      logic             fetch;
   } mem_cycle_s;

   typedef struct packed {
      logic             valid;
      logic [3:0]       num;
      logic [BUS_W-1:0] data;
   } reg_write_s;

   typedef struct packed {
      trace_kind_e      kind;
      logic [BUS_W-1:0] addr;
      logic [BUS_W-1:0] data;
   } trace_entry_s;

   // Masked compare shared by both trigger kinds
   function automatic logic cmp_hit(cmp_op_e op, logic [BUS_W-1:0] val,
                                    logic [BUS_W-1:0] refv, logic [BUS_W-1:0] mask);
      logic [BUS_W-1:0] a;
      logic [BUS_W-1:0] b;
      a = val & mask;
      b = refv & mask;
      case (op)
         CMP_EQ:  cmp_hit = (a == b);
         CMP_NE:  cmp_hit = (a != b);
         CMP_GE:  cmp_hit = (a >= b);
         default: cmp_hit = (a <= b);
      endcase
   endfunction : cmp_hit

endpackage : emul_trig_pkg
`default_nettype wire

// File: dv/jtag_dbg.sv
`default_nettype none
module jtag_dbg (
   output logic      tck,
   output logic      sel,
   output logic      tdi,
   input  wire logic tdo
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      tck = 1'b0;
      sel = 1'b0;
      tdi = 1'b1;
   end

   // One link clock pulse, 80 ns period
   task automatic tick;
      #40 tck = 1'b1;
      #40 tck = 1'b0;
   endtask : tick

   // Frame out MSB first, readback of previous frame in
   task automatic xfer(input logic [7:0] a, input logic [31:0] d, output logic [31:0] rb);
      logic [39:0] f;
      f = {a, d};
      rb = '0;
      for (int i = 39; i >= 0; i--) begin
         sel = 1'b1;
         tdi = f[i];
         tick();
         if (i >= 8) rb = {rb[30:0], tdo};
      end
      sel = 1'b0;
      tdi = ~tdi;
      tick();
      #300;
   endtask : xfer
endmodule : jtag_dbg
`default_nettype wire

// File: dv/tb.sv
`default_nettype none
module tb
   import emul_trig_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;

   logic             clock, nrst, tck, sel, tdi, tdo, stop, e;
   mem_cycle_s       mc;
   reg_write_s       rw;
   logic [TRIGS-1:0] hit;
   logic [1:0]       state;
   logic [7:0]       prun;
   logic [31:0]      rf, ct, x;
   logic [15:0]      a, d, m;
   logic [3:0]       q, nm;
   logic [15:0]      ea [8];
   logic [15:0]      ed [8];
   logic [1:0]       ek [8];
   int               t, failures, cmp_count;

   emul_trig_seq dut_u (.CLOCK(clock), .NRST(nrst), .MEM_CYCLE(mc), .REG_WRITE(rw),
      .JTAG_TCK(tck), .JTAG_SEL(sel), .JTAG_TDI(tdi), .JTAG_TDO(tdo), .CPU_STOP(stop),
      .TRIG_HIT(hit), .SEQ_STATE(state), .PERIPH_CLK_RUN(prun));
   jtag_dbg dbg_u (.tck(tck), .sel(sel), .tdi(tdi), .tdo(tdo));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] g);
      cmp_count++;
      if (g !== ex) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, ex, g);
      end
   endtask : chk

   task automatic wr(input logic [3:0] g, input logic [3:0] i, input logic [31:0] v);
      logic [31:0] y;
      dbg_u.xfer({g, i}, v, y);
   endtask : wr

   task automatic rd(input logic [3:0] g, input logic [3:0] i, output logic [31:0] v);
      logic [31:0] y;
      dbg_u.xfer({g, i}, 32'h0, y);
      dbg_u.xfer({GRP_STATUS, 4'h0}, 32'h0, v);
   endtask : rd

   task automatic cyc(input logic [15:0] ad, input logic [15:0] dd, input logic [3:0] k);
      @(posedge clock) #2;
      mc = {ad, dd, 1'b1, k[0], k[1], k[2], k[3]};
      @(posedge clock) #2;
      mc.valid = 1'b0;
   endtask : cyc

   task automatic fire(input int i);
      cyc(16'h1000 + i[15:0], 16'h0, 4'h0);
      @(posedge clock) #2;
   endtask : fire

   function automatic logic fcmp(logic [1:0] op, logic [15:0] v, logic [15:0] r,
                                 logic [15:0] mk);
      case (op)
         2'h0:    return (v & mk) == (r & mk);
         2'h1:    return (v & mk) != (r & mk);
         2'h2:    return (v & mk) >= (r & mk);
         default: return (v & mk) <= (r & mk);
      endcase
   endfunction : fcmp

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   initial begin
      #1000000;
      failures++;
      complete_run();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      mc = '0;
      rw = '0;
      x = $urandom(57);
      repeat (6) @(posedge clock);
      chk("reset_run", 8'hff, prun);
      chk("reset_state", 0, {stop, hit, state});
      #2 nrst = 1'b1;
      for (int n = 0; n < 12; n++) begin
         t = $urandom_range(7);
         rf = $urandom;
         ct = ($urandom & 32'h17f) | 32'h80;
         wr(GRP_MEM_REF, t[3:0], rf);
         wr(GRP_MEM_CTL, t[3:0], ct);
         a = n[0] ? rf[15:0] : 16'($urandom);
         d = n[1] ? rf[15:0] : 16'($urandom);
         q = 4'($urandom);
         m = ct[8] ? {{8{rf[17]}}, {8{rf[16]}}} : rf[31:16];
         e = fcmp(ct[2:1], ct[0] ? d : a, rf[15:0], m) && (ct[6:3] == 0 || (ct[6:3] & q) != 0);
         cyc(a, d, q);
         chk("mem_hit", e, hit[t]);
         @(posedge clock) #2;
         chk("hit_pulse", 0, hit[t]);
      end
      for (int n = 0; n < 8; n++) begin
         t = $urandom_range(1);
         rf = $urandom;
         ct = ($urandom & 32'h3f) | 32'h40;
         wr(GRP_REG_REF, t[3:0], rf);
         wr(GRP_REG_CTL, t[3:0], ct);
         nm = n[0] ? ct[3:0] : 4'($urandom);
         d = n[1] ? rf[15:0] : 16'($urandom);
         e = (nm == ct[3:0]) && fcmp(ct[5:4], d, rf[15:0], rf[31:16]);
         @(posedge clock) #2;
         rw = {1'b1, nm, d};
         @(posedge clock) #2;
         rw.valid = 1'b0;
         chk("reg_hit", e, hit[8+t]);
      end
      for (int i = 0; i < 3; i++) begin
         wr(GRP_MEM_REF, i[3:0], 32'hffff1000 + i);
         wr(GRP_MEM_CTL, i[3:0], 32'h80);
         wr(GRP_COMB, i[3:0], 32'h1 << i);
      end
      wr(GRP_CLK, 4'h0, 32'h5a);
      wr(GRP_REACT, 4'h0, 32'h10001);
      wr(GRP_SEQ, 4'h0, 32'h79);
      wr(GRP_SEQ, 4'h3, 32'h63);
      wr(GRP_SEQ, SEQ_RST_IDX, 32'ha);
      fire(0);
      chk("stop_gated", 0, {stop, state});
      fire(1);
      chk("seq_skip", 3, state);
      fire(2);
      chk("seq_reset", 0, state);
      fire(1);
      fire(0);
      chk("stop", 1, stop);
      @(posedge clock) #2;
      chk("clk_module", 8'h5a, prun);
      wr(GRP_CMD, 4'h0, 32'h2);
      chk("release", {1'b0, 8'hff}, {stop, prun});
      wr(GRP_CLK, 4'h0, 32'h100);
      fire(0);
      @(posedge clock) #2;
      chk("clk_glob_stop", 8'h00, prun);
      wr(GRP_CLK, 4'h0, 32'h300);
      chk("clk_glob_run", 8'hff, prun);
      rd(GRP_CLK, 4'h0, x);
      chk("clk_readback", 32'h300, x);
      rd(GRP_MEM_CTL, 4'h2, x);
      chk("ctl_readback", 32'h80, x);
      wr(GRP_CMD, 4'h0, 32'h2);
      wr(GRP_REACT, 4'h0, 32'h100);
      wr(GRP_MEM_REF, 4'h0, 32'h0);
      wr(GRP_CMD, 4'h0, 32'h1);
      for (int n = 0; n < 10; n++) begin
         t = $urandom_range(2);
         a = $urandom;
         d = $urandom;
         q = (t == 0) ? 4'h1 : (t == 1) ? 4'h2 : 4'h8;
         if (n < 8) {ea[n], ed[n], ek[n]} = {a, d, t[1:0]};
         cyc(a, d, q);
      end
      rd(GRP_STATUS, 4'h0, x);
      chk("trace_count", 8, x[3:0]);
      for (int i = 0; i < 8; i++) begin
         rd(GRP_TRACE, i[3:0], x);
         chk("trace_word", {ea[i], ed[i]}, x);
         rd(GRP_KIND, i[3:0], x);
         chk("trace_kind", ek[i], x[1:0]);
      end
      wr(GRP_CMD, 4'h0, 32'h1);
      rd(GRP_STATUS, 4'h0, x);
      chk("rearm_count", 0, x[3:0]);
      complete_run();
   end
endmodule : tb
`default_nettype wire
